/* File: dli_flash.sv */
// Purpose: common flash phase generator
// Assumes: single clock, synchronous reset
// Notes: phase toggles every half period
`timescale 1ns/10ps
`default_nettype none
module dli_flash #(
  parameter int HALF_CYC = dli_pkg::FLASH_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic phase_o
);
  logic [31:0] cnt_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 32'h0;
      phase_o <= 1'b0;
    end else if (cnt_r == 32'(HALF_CYC - 1)) begin
      cnt_r <= 32'h0;
      phase_o <= ~phase_o;
    end else begin
      cnt_r <= cnt_r + 32'h1;
    end
  end
endmodule
`default_nettype wire

/* File: dli_observer.sv */
// Purpose: operator model that reads the leds
// Assumes: one look per request
// Notes: flags white on a reserved position
`timescale 1ns/10ps
`default_nettype none
module dli_observer (
  input wire logic clk_i,
  input wire logic look_i,
  input wire logic [23:0] diag_i,
  input wire logic [3:0] field_i,
  output logic seen_v_o,
  output logic [28:0] seen_o
);
  logic white_rsv;
  always_comb begin
    white_rsv = diag_i[5:3] == dli_pkg::COL_WHITE;
    for (int i = 4; i < 8; i++) begin
      if (diag_i[3*i+:3] == dli_pkg::COL_WHITE) white_rsv = 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    seen_v_o <= look_i;
    if (look_i) seen_o <= {white_rsv, field_i, diag_i};
  end
endmodule
`default_nettype wire

/* File: dli_pkg.sv */
// Purpose: constants for the diagnostic led indicator
// Assumes: 125 MHz clock, classic wishbone register access
// Notes: one word per register, byte addresses
package dli_pkg;
  localparam int CLK_HZ = 125_000_000;
  localparam int FLASH_MS = 250;
  localparam int FLASH_CYC = (CLK_HZ / 1000) * FLASH_MS;
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_IRQ = 8'h08;
  localparam logic [7:0] ADR_MASK = 8'h0C;
  localparam logic [7:0] ADR_FAULT = 8'h10;
  localparam logic [7:0] ADR_WARN = 8'h14;
  // ctrl bits
  localparam int CB_SHOWCFG = 0;
  // status bits
  localparam int SB_FEEDBACK = 0;
  localparam int SB_CODING = 1;
  localparam int SB_RESTART = 2;
  localparam int SB_SYNC_FAR = 3;
  localparam int SB_SYNC_NEAR = 4;
  localparam int SB_FAULT = 5;
  localparam int SB_WARN = 6;
  localparam int SB_FIELD = 7;
  // interrupt bits
  localparam int IB_FAULT = 0;
  localparam int IB_WARN = 1;
  localparam int IB_SYNC = 2;
  localparam logic [2:0] IRQ_NONE = 3'h0;
  // led colour codes
  localparam logic [2:0] COL_OFF = 3'h0;
  localparam logic [2:0] COL_WHITE = 3'h1;
  localparam logic [2:0] COL_BLUE = 3'h2;
  localparam logic [2:0] COL_RED = 3'h3;
  localparam logic [2:0] COL_YELLOW = 3'h4;
  // field indicator colours
  localparam logic [1:0] FLD_RED = 2'h1;
  localparam logic [1:0] FLD_YELLOW = 2'h2;
  localparam logic [1:0] FLD_GREEN = 2'h3;
  // diagnostic led indices (led n at index n-1)
  localparam int LED_FEEDBACK = 0;
  localparam int LED_CODING = 2;
  localparam int LED_RESTART = 3;
  localparam int LED_CAUSE_FEEDBACK = 4;
  localparam int DIAG_LEDS = 8;
  localparam int BAR_LEDS = 4;
endpackage

/* File: dli_top.sv */
// Purpose: receiver diagnostic and field indicator led driver
// Assumes: status inputs come from core logic on clk_i
// Notes: registers over classic wishbone, one level interrupt
`timescale 1ns/10ps
`default_nettype none
module dli_top #(
  parameter int FIELD_LEDS = 1,
  parameter int FLASH_HALF = dli_pkg::FLASH_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic contactor_feedback_monitoring_i,
  input wire logic coding_en_i,
  input wire logic restart_en_i,
  input wire logic [2:0] align_i,
  input wire logic sync_far_i,
  input wire logic sync_near_i,
  input wire logic fault_i,
  input wire logic [2:0] fault_func_i,
  input wire logic [2:0] fault_cause_i,
  input wire logic warn_i,
  input wire logic [2:0] warn_func_i,
  input wire logic [2:0] warn_cause_i,
  input wire logic field_clear_i,
  output logic [23:0] diag_o,
  output logic [2*FIELD_LEDS-1:0] field_o
);
  logic show_cfg_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_mask_r;
  logic sync_q_r;
  logic fault_q_r;
  logic warn_q_r;
  logic phase;
  logic [2:0] col [dli_pkg::DIAG_LEDS];
  logic [23:0] diag_nxt;
  logic [1:0] field_col;
  logic req;
  logic [2:0] ev;
  logic [2:0] clr;
  localparam logic [2:0] IRQ_ZERO = dli_pkg::IRQ_NONE;

  dli_flash #(.HALF_CYC(FLASH_HALF)) u_flash (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .phase_o(phase)
  );

  // number of bar leds lit for a quality level, at least one
  function automatic logic [3:0] bar_mask(input logic [2:0] q);
    logic [3:0] m;
    m = 4'h1;
    if (q >= 3'h2) m = 4'h3;
    if (q >= 3'h4) m = 4'h7;
    if (q >= 3'h6) m = 4'hF;
    return m;
  endfunction

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) wb_ack_o <= 1'b0;
    else wb_ack_o <= req;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      show_cfg_r <= 1'b0;
      irq_mask_r <= IRQ_ZERO;
    end else if (req && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == dli_pkg::ADR_CTRL)
        show_cfg_r <= wb_dat_i[dli_pkg::CB_SHOWCFG];
      if (wb_adr_i == dli_pkg::ADR_MASK)
        irq_mask_r <= wb_dat_i[2:0];
    end
  end

  // event edges: fault or warning raised, sync lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_q_r <= 1'b0;
      fault_q_r <= 1'b0;
      warn_q_r <= 1'b0;
    end else begin
      sync_q_r <= sync_far_i & sync_near_i;
      fault_q_r <= fault_i;
      warn_q_r <= warn_i;
    end
  end
  always_comb begin
    ev = IRQ_ZERO;
    ev[dli_pkg::IB_FAULT] = fault_i & ~fault_q_r;
    ev[dli_pkg::IB_WARN] = warn_i & ~warn_q_r;
    ev[dli_pkg::IB_SYNC] = sync_q_r & ~(sync_far_i & sync_near_i);
    clr = IRQ_ZERO;
    if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == dli_pkg::ADR_IRQ)
      clr = wb_dat_i[2:0];
  end
  // set wins over write-one-to-clear
  always_ff @(posedge clk_i) begin
    if (rst_i) irq_stat_r <= IRQ_ZERO;
    else irq_stat_r <= (irq_stat_r & ~clr) | ev;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) irq_o <= 1'b0;
    else irq_o <= |(((irq_stat_r & ~clr) | ev) & irq_mask_r);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (req && !wb_we_i) begin
      case (wb_adr_i)
        dli_pkg::ADR_CTRL: wb_dat_o <= {31'h0, show_cfg_r};
        dli_pkg::ADR_STAT: wb_dat_o <= {24'h0, field_clear_i, warn_i,
          fault_i, sync_near_i, sync_far_i, restart_en_i, coding_en_i,
          contactor_feedback_monitoring_i};
        dli_pkg::ADR_IRQ: wb_dat_o <= {29'h0, irq_stat_r};
        dli_pkg::ADR_MASK: wb_dat_o <= {29'h0, irq_mask_r};
        dli_pkg::ADR_FAULT: wb_dat_o <= {26'h0, fault_cause_i,
          fault_func_i};
        dli_pkg::ADR_WARN: wb_dat_o <= {26'h0, warn_cause_i, warn_func_i};
        default: wb_dat_o <= 32'h0;
      endcase
    end
  end

  // led colour choice; fault beats warning beats config beats alignment
  always_comb begin
    logic [3:0] bar;
    bar = bar_mask(align_i);
    for (int i = 0; i < dli_pkg::DIAG_LEDS; i++) col[i] = dli_pkg::COL_OFF;
    if (fault_i) begin
      col[fault_func_i] = dli_pkg::COL_RED;
      if (phase) col[fault_cause_i] = dli_pkg::COL_RED;
    end else if (warn_i) begin
      col[warn_func_i] = dli_pkg::COL_YELLOW;
      if (phase) col[warn_cause_i] = dli_pkg::COL_YELLOW;
    end else if (show_cfg_r) begin
      // other positions stay off here
      if (contactor_feedback_monitoring_i)
        col[dli_pkg::LED_FEEDBACK] = dli_pkg::COL_WHITE;
      if (coding_en_i)
        col[dli_pkg::LED_CODING] = dli_pkg::COL_WHITE;
      if (restart_en_i)
        col[dli_pkg::LED_RESTART] = dli_pkg::COL_WHITE;
    end else begin
      for (int i = 0; i < dli_pkg::BAR_LEDS; i++)
        if (bar[i]) col[i] = dli_pkg::COL_BLUE;
      if (sync_far_i) begin
        col[4] = dli_pkg::COL_BLUE;
        col[5] = dli_pkg::COL_BLUE;
      end
      if (sync_near_i) begin
        col[6] = dli_pkg::COL_BLUE;
        col[7] = dli_pkg::COL_BLUE;
      end
    end
    diag_nxt = 24'h0;
    for (int i = 0; i < dli_pkg::DIAG_LEDS; i++)
      diag_nxt[3*i +: 3] = col[i];
  end

  always_comb begin
    if (fault_i) field_col = dli_pkg::FLD_RED;
    else if (warn_i) field_col = dli_pkg::FLD_YELLOW;
    else if (field_clear_i) field_col = dli_pkg::FLD_GREEN;
    else field_col = dli_pkg::FLD_RED;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      diag_o <= 24'h0;
      field_o <= '0;
    end else begin
      diag_o <= diag_nxt;
      field_o <= {FIELD_LEDS{field_col}};
    end
  end

  // checks
  bar_min_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fault_i && !warn_i && !show_cfg_r) |=>
    diag_o[2:0] == dli_pkg::COL_BLUE)
    else $error("bar led one not blue");
  far_sync_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fault_i && !warn_i && !show_cfg_r && sync_far_i) |=>
    diag_o[14:12] == dli_pkg::COL_BLUE && diag_o[17:15] ==
    dli_pkg::COL_BLUE)
    else $error("far sync leds wrong");
  near_sync_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fault_i && !warn_i && !show_cfg_r && !sync_near_i) |=>
    diag_o[23:21] == dli_pkg::COL_OFF)
    else $error("near sync led lit");
  cfg_feedback_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fault_i && !warn_i && show_cfg_r) |=>
    (diag_o[2:0] == dli_pkg::COL_WHITE) ==
    $past(contactor_feedback_monitoring_i))
    else $error("feedback led wrong");
  cfg_coding_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fault_i && !warn_i && show_cfg_r && coding_en_i) |=>
    diag_o[8:6] == dli_pkg::COL_WHITE)
    else $error("coding led not white");
  cfg_restart_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fault_i && !warn_i && show_cfg_r && restart_en_i) |=>
    diag_o[11:9] == dli_pkg::COL_WHITE)
    else $error("restart led not white");
  cfg_reserved_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fault_i && !warn_i && show_cfg_r) |=>
    diag_o[5:3] != dli_pkg::COL_WHITE &&
    diag_o[23:12] == 12'h0)
    else $error("reserved led white");
  fault_func_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fault_i && fault_func_i == 3'h0) |=>
    diag_o[2:0] == dli_pkg::COL_RED)
    else $error("fault function led not red");
  fault_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fault_i && phase && fault_cause_i == 3'h4) |=>
    diag_o[14:12] == dli_pkg::COL_RED)
    else $error("fault cause led not red");
  warn_func_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fault_i && warn_i && warn_func_i == 3'h3) |=>
    diag_o[11:9] == dli_pkg::COL_YELLOW)
    else $error("warning function led not yellow");
  warn_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fault_i && warn_i && !phase && warn_cause_i != warn_func_i &&
    warn_cause_i == 3'h6) |=> diag_o[20:18] == dli_pkg::COL_OFF)
    else $error("warning cause led lit in off phase");
  flash_rate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(phase) |=> $stable(phase))
    else $error("flash phase toggles too fast");
  field_all_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_i |=> field_o == {FIELD_LEDS{dli_pkg::FLD_RED}})
    else $error("field leds not all red");
  irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (irq_stat_r & irq_mask_r) != IRQ_ZERO && clr == IRQ_ZERO |=> irq_o)
    else $error("interrupt not raised");
  near_sync_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fault_i && !warn_i && !show_cfg_r && sync_near_i) |=>
    diag_o[23:18] == {2{dli_pkg::COL_BLUE}})
    else $error("near sync leds not blue");
  far_sync_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fault_i && !warn_i && !show_cfg_r && !sync_far_i) |=>
    diag_o[17:12] == 6'h00)
    else $error("far sync leds lit");
  bar_full_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fault_i && !warn_i && !show_cfg_r && align_i >= 3'h6) |=>
    diag_o[11:0] == {4{dli_pkg::COL_BLUE}})
    else $error("full bar not lit");
  bar_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fault_i && !warn_i && !show_cfg_r && align_i < 3'h2) |=>
    diag_o[11:3] == 9'h000)
    else $error("low bar too long");
  cfg_coding_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fault_i && !warn_i && show_cfg_r && !coding_en_i) |=>
    diag_o[8:6] == dli_pkg::COL_OFF)
    else $error("coding led lit");
  cfg_restart_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fault_i && !warn_i && show_cfg_r && !restart_en_i) |=>
    diag_o[11:9] == dli_pkg::COL_OFF)
    else $error("restart led lit");
  fault_cause_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fault_i && !phase && fault_func_i != 3'h4 &&
    fault_cause_i == 3'h4) |=> diag_o[14:12] == dli_pkg::COL_OFF)
    else $error("fault cause led lit in off phase");
  warn_cause_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fault_i && warn_i && phase && warn_cause_i == 3'h6) |=>
    diag_o[20:18] == dli_pkg::COL_YELLOW)
    else $error("warning cause led not yellow");
  fault_pair_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fault_i && phase && fault_func_i == 3'h0 && fault_cause_i == 3'h4)
    |=> diag_o[2:0] == dli_pkg::COL_RED &&
    diag_o[14:12] == dli_pkg::COL_RED)
    else $error("feedback fault pair wrong");
  fault_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fault_i && fault_func_i != 3'h0 && fault_cause_i != 3'h0) |=>
    diag_o[2:0] == dli_pkg::COL_OFF)
    else $error("unrelated led lit on fault");
  warn_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fault_i && warn_i && warn_func_i != 3'h7 && warn_cause_i != 3'h7)
    |=> diag_o[23:21] == dli_pkg::COL_OFF)
    else $error("unrelated led lit on warning");
  warn_no_blue_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fault_i && warn_i && warn_func_i != 3'h4 && warn_cause_i != 3'h4)
    |=> diag_o[14:12] == dli_pkg::COL_OFF)
    else $error("sync led lit on warning");
  fault_over_cfg_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fault_i && show_cfg_r && fault_func_i != 3'h0 &&
    fault_cause_i != 3'h0) |=> diag_o[2:0] != dli_pkg::COL_WHITE)
    else $error("white led shown over fault");
  field_warn_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fault_i && warn_i) |=>
    field_o == {FIELD_LEDS{dli_pkg::FLD_YELLOW}})
    else $error("field leds not all yellow");
  field_free_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fault_i && !warn_i && field_clear_i) |=>
    field_o == {FIELD_LEDS{dli_pkg::FLD_GREEN}})
    else $error("field leds not all green");
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> wb_ack_o)
    else $error("request not acknowledged");
  irq_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ((irq_stat_r | ev) & irq_mask_r) == IRQ_ZERO |=> !irq_o)
    else $error("interrupt without unmasked status");
  irq_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ev != IRQ_ZERO |=> (irq_stat_r & $past(ev)) == $past(ev))
    else $error("event lost against clear");

  fault_seen_c: cover property (@(posedge clk_i) fault_i && phase);
  warn_seen_c: cover property (@(posedge clk_i) !fault_i && warn_i);
  cfg_seen_c: cover property (@(posedge clk_i) show_cfg_r && coding_en_i);
  sync_seen_c: cover property (@(posedge clk_i) sync_far_i && sync_near_i);
  irq_seen_c: cover property (@(posedge clk_i) irq_o);
endmodule
`default_nettype wire

/* File: dli_top_tb.sv */
// Purpose: self-checking bench for the led indicator
// Assumes: flash half period of 4 cycles, two field leds
// Notes: observer led results go through an expectation queue
`timescale 1ns/10ps
`default_nettype none
module dli_top_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic fbm = 1'b0, cod = 1'b0, rsi = 1'b0, far = 1'b0, near = 1'b0;
  logic flt = 1'b0, wrn = 1'b0, clr = 1'b0, look = 1'b0;
  logic [2:0] align = 3'h0, ff = 3'h0, fc = 3'h0, wf = 3'h0, wc = 3'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, irq_o, seen_v;
  logic [23:0] diag_o;
  logic [3:0] field_o;
  logic [28:0] seen, e_v, e_m;
  logic [28:0] q_val[$], q_msk[$];
  logic [31:0] q_rd[$];
  logic [7:0] s = 8'h2C;
  int err_total = 0, samples_checked = 0;

  always #4 clk_i = ~clk_i;

  dli_top #(.FIELD_LEDS(2), .FLASH_HALF(4)) i_dut (.clk_i(clk_i),
    .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq_o(irq_o), .contactor_feedback_monitoring_i(fbm),
    .coding_en_i(cod), .restart_en_i(rsi), .align_i(align),
    .sync_far_i(far), .sync_near_i(near), .fault_i(flt),
    .fault_func_i(ff), .fault_cause_i(fc), .warn_i(wrn),
    .warn_func_i(wf), .warn_cause_i(wc), .field_clear_i(clr),
    .diag_o(diag_o), .field_o(field_o));
  dli_observer i_obs (.clk_i(clk_i), .look_i(look), .diag_i(diag_o),
    .field_i(field_o), .seen_v_o(seen_v), .seen_o(seen));

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  function automatic logic [28:0] bar(input logic [2:0] a,
      input logic f, input logic n, input logic c);
    logic [28:0] e;
    logic [1:0] fl;
    e = 29'h0;
    fl = c ? dli_pkg::FLD_GREEN : dli_pkg::FLD_RED;
    for (int i = 0; i < 4; i++) begin
      if (i <= a / 2) e[3*i+:3] = dli_pkg::COL_BLUE;
    end
    if (f) e[17:12] = {2{dli_pkg::COL_BLUE}};
    if (n) e[23:18] = {2{dli_pkg::COL_BLUE}};
    e[27:24] = {fl, fl};
    return e;
  endfunction

  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      summarize();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    q_rd.push_back(exp);
    wb(1'b0, a, 32'h0);
  endtask

  task automatic see(input logic [28:0] v, input logic [28:0] m);
    repeat (2) @(posedge clk_i);
    q_val.push_back(v);
    q_msk.push_back(m);
    look <= 1'b1;
    @(posedge clk_i);
    look <= 1'b0;
  endtask

  task automatic flash(input int idx, input logic [2:0] col, input int n);
    int c;
    c = 0;
    @(posedge clk_i);
    repeat (16) begin
      @(posedge clk_i);
      if (diag_o[3*idx+:3] === col) c++;
    end
    chk(c, n);
  endtask

  // every position as function led, cause on the mirrored one
  task automatic fw(input logic [2:0] col);
    for (int f = 0; f < 8; f++) begin
      ff <= f[2:0];
      fc <= ~f[2:0];
      wf <= f[2:0];
      wc <= ~f[2:0];
      see({26'h0, col} << (3 * f), (29'h7 << (3 * f)) | 29'h1000_0000);
    end
  endtask

  always @(posedge clk_i) begin
    if (seen_v === 1'b1 && q_val.size() > 0) begin
      e_v = q_val.pop_front();
      e_m = q_msk.pop_front();
      chk({3'h0, seen & e_m}, {3'h0, e_v & e_m});
    end
    if (wb_ack_o === 1'b1 && !wb_we_i && q_rd.size() > 0) begin
      chk(wb_dat_o, q_rd.pop_front());
    end
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({irq_o, field_o, diag_o}, 32'h0);
    rd(8'h20, 32'h0);
    for (int i = 0; i < 8; i++) begin
      s = lfsr(s);
      align <= i[2:0];
      far <= s[0];
      near <= s[1];
      clr <= s[2];
      {fbm, cod, rsi} <= s[5:3];
      see(bar(i[2:0], s[0], s[1], s[2]), 29'h1FFF_FFFF);
      rd(dli_pkg::ADR_STAT, {24'h0, s[2], 2'h0, s[1:0], s[3], s[4], s[5]});
    end
    wb(1'b1, dli_pkg::ADR_CTRL, 32'h1);
    for (int i = 0; i < 8; i++) begin
      {fbm, cod, rsi} <= i[2:0];
      see({17'h0, {3{i[0]}} & dli_pkg::COL_WHITE,
        {3{i[1]}} & dli_pkg::COL_WHITE, 3'h0,
        {3{i[2]}} & dli_pkg::COL_WHITE}, 29'h1000_0FFF);
    end
    wb(1'b1, dli_pkg::ADR_CTRL, 32'h0);
    far <= 1'b1;
    near <= 1'b1;
    wb(1'b1, dli_pkg::ADR_IRQ, 32'h7);
    repeat (3) @(posedge clk_i);
    chk(irq_o, 1'b0);
    flt <= 1'b1;
    fw(dli_pkg::COL_RED);
    flash(0, dli_pkg::COL_RED, 8);
    ff <= 3'h0;
    fc <= 3'h4;
    flash(4, dli_pkg::COL_RED, 8);
    flash(0, dli_pkg::COL_RED, 16);
    rd(dli_pkg::ADR_IRQ, 32'h1);
    chk(irq_o, 1'b0);
    rd(dli_pkg::ADR_FAULT, 32'h20);
    wb(1'b1, dli_pkg::ADR_MASK, 32'h1);
    repeat (3) @(posedge clk_i);
    chk(irq_o, 1'b1);
    wb(1'b1, dli_pkg::ADR_IRQ, 32'h1);
    wb(1'b1, dli_pkg::ADR_MASK, 32'h0);
    repeat (3) @(posedge clk_i);
    chk(irq_o, 1'b0);
    flt <= 1'b0;
    wrn <= 1'b1;
    fw(dli_pkg::COL_YELLOW);
    flash(0, dli_pkg::COL_YELLOW, 8);
    flash(7, dli_pkg::COL_YELLOW, 16);
    far <= 1'b0;
    near <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd(dli_pkg::ADR_IRQ, 32'h6);
    wb(1'b1, dli_pkg::ADR_IRQ, 32'h7);
    repeat (3) @(posedge clk_i);
    chk(irq_o, 1'b0);
    summarize();
  end
endmodule
`default_nettype wire
